// ===== pfr_pkg.sv
// constants and carrier types for the printer fault and ready logic
// assumes one 100 MHz clock and sensors already synchronous to it
//
// Overview of operation
// [R01] fuse alarm lamp lit while any actuator fuse blown; ready returns after replacement
// [R02] dc fault lamp lit on supply fault; ready follows 45 s timing cycle
// [R03] overrun lamp set after 22 inches of continuous automatic feed
// [R04] overrun lamp held until ready switch pressed, then printer ready again
// [R05] manually advanced paper never counts toward overrun
// [R06] paper low lamp lit when 2.5 inches remain below print head
// [R07] ready once paper corrected; paper low lamp cleared by ready switch
// [R08] cabinet lamp follows open, undefeated interlock; ready after 45 s cycle
// [R09] ribbon lamp set on ribbon reversal while swap request active
// [R10] swap request press clears ribbon lamp; ready switch then restores ready
// [R11] thermal lamp on overheat or airflow loss; ready after 45 s cycle (code: lamp follows overtemp only, air_loss reaches controller summary only)
// [R12] printer summary lamp ORs ribbon, dc, overrun, carriage, heat, interlock
// [R13] controller summary lamp ORs low volt, high current, heat, air loss
// [R14] misset lamp lit when any maintenance switch is off normal
// [R15] power key green when powered, red when dc off; press turns off
// [R16] in 62 character mode codes 05 and 77 octal are not printed
// [R17] in 62 character mode code 77 suppresses rest of line
// [R18] in 63 character mode only code 05 octal is suppressed
// [R19] after power on with no faults, ready follows 45 s delay
// [R20] ready only with no blocking lamp and no timing cycle running

package pfr_pkg;

	// -----------------------------------------------------------------
	// timing
	// -----------------------------------------------------------------
	localparam longint unsigned TIMER_SECONDS = 64'd45;
	localparam longint unsigned CLK_HZ = 64'd100_000_000;
	localparam longint unsigned TIMER_CYCLES_DFLT = TIMER_SECONDS * CLK_HZ;

	// -----------------------------------------------------------------
	// paper feed
	// -----------------------------------------------------------------
	localparam int unsigned OVERRUN_INCHES = 22;
	// feed steps per inch of paper travel
	localparam int unsigned STEPS_PER_INCH_DFLT = 6;

	// -----------------------------------------------------------------
	// character codes (octal 05 and 77)
	// -----------------------------------------------------------------
	localparam logic [5:0] CODE_BLANK = 6'h05;
	localparam logic [5:0] CODE_STOP = 6'h3f;

	// -----------------------------------------------------------------
	// carriers
	// -----------------------------------------------------------------
	typedef struct packed {
		logic fuse_blown;
		logic dc_fault;
		logic paper_low;
		logic interlock_open;
		logic interlock_defeat;
		logic overtemp;
		logic carriage_out;
	} pfr_sense_t;

	typedef struct packed {
		logic low_volt;
		logic high_cur;
		logic high_temp;
		logic air_loss;
	} pfr_ctl_t;

	typedef struct packed {
		logic valid;
		logic [5:0] code;
	} pfr_char_t;

endpackage

// ===== pfr_status.sv
// printer fault lamps, ready condition, controller lamps, character filter
// assumes sensor levels and one-cycle button/feed pulses synchronous to mclk_i
module pfr_status import pfr_pkg::*; #(
	parameter longint unsigned TIMER_CYCLES = TIMER_CYCLES_DFLT,
	parameter int unsigned STEPS_PER_INCH = STEPS_PER_INCH_DFLT,
	parameter int unsigned MAINT_SW = 8
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire pfr_sense_t sense_i,
	input wire logic feed_step_i,
	input wire logic manual_feed_i,
	input wire logic feed_stop_i,
	input wire logic ready_btn_i,
	input wire logic ribbon_swap_btn_i,
	input wire logic ribbon_reverse_i,
	input wire pfr_ctl_t ctl_i,
	input wire logic [MAINT_SW-1:0] maint_off_normal_i,
	input wire logic ctl_power_on_i,
	input wire logic dc_power_on_i,
	input wire logic power_key_btn_i,
	input wire logic charset63_i,
	input wire logic line_start_i,
	input wire pfr_char_t char_i,
	output logic actuator_fuse_alarm_o,
	output logic dc_fault_lamp_o,
	output logic paper_feed_overrun_o,
	output logic paper_low_lamp_o,
	output logic cabinet_open_lamp_o,
	output logic ribbon_swap_request_o,
	output logic ribbon_exhausted_lamp_o,
	output logic thermal_alarm_o,
	output logic ready_o,
	output logic printer_summary_alarm_o,
	output logic controller_summary_alarm_o,
	output logic maintenance_misset_lamp_o,
	output logic key_green_o,
	output logic key_red_o,
	output logic ctl_off_req_o,
	output pfr_char_t char_o
);

	// -----------------------------------------------------------------
	// sizes and elaboration checks
	// -----------------------------------------------------------------
	localparam int unsigned RUN_LIMIT = OVERRUN_INCHES * STEPS_PER_INCH;
	localparam int RW = $clog2(RUN_LIMIT + 1);
	localparam int TW = $clog2(TIMER_CYCLES + 64'd1);
	localparam logic [TW-1:0] TMR_LOAD = TW'(TIMER_CYCLES);
	localparam logic [TW-1:0] TMR_ONE = TW'(64'd1);
	localparam logic [RW-1:0] RUN_END = RW'(RUN_LIMIT);
	localparam logic [RW-1:0] RUN_ONE = RW'(1);

	if (TIMER_CYCLES < 64'd2 || STEPS_PER_INCH < 1 || MAINT_SW < 1) begin
		$error("pfr_status: parameter out of range");
	end

	function automatic logic printable(input logic [5:0] code,
		input logic cs63, input logic stopped);
		printable = code != CODE_BLANK &&
			(cs63 || (code != CODE_STOP && !stopped));
	endfunction

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	logic [TW-1:0] tmr_reg, tmr_next;
	logic [RW-1:0] run_reg, run_next;
	logic overrun_reg, overrun_next;
	logic low_lamp_reg, low_lamp_next;
	logic swap_reg, swap_next;
	logic rib_lamp_reg, rib_lamp_next;
	logic rib_hold_reg, rib_hold_next;
	logic stop_seen_reg, stop_seen_next;
	logic ready_next;

	// -----------------------------------------------------------------
	// fault decode
	// -----------------------------------------------------------------
	wire cab_open = sense_i.interlock_open && !sense_i.interlock_defeat; // R08
	wire timed_fault = sense_i.dc_fault || cab_open || sense_i.overtemp;
	wire tmr_zero = tmr_reg == '0;

	// -----------------------------------------------------------------
	// 45 s timing cycle, loaded at reset for the power-on delay
	// -----------------------------------------------------------------
	assign tmr_next = timed_fault ? TMR_LOAD : // R02 R08 R11
		(tmr_zero ? tmr_reg : tmr_reg - TMR_ONE); // R19

	// -----------------------------------------------------------------
	// forms runaway
	// -----------------------------------------------------------------
	wire run_hit = feed_step_i && run_reg == RUN_END - RUN_ONE; // R03
	assign run_next = (feed_stop_i || run_hit) ? '0 :
		(feed_step_i ? run_reg + RUN_ONE : run_reg); // R05
	assign overrun_next = run_hit ||
		(overrun_reg && !ready_btn_i); // R04

	// -----------------------------------------------------------------
	// forms out
	// -----------------------------------------------------------------
	assign low_lamp_next = sense_i.paper_low ||
		(low_lamp_reg && !ready_btn_i); // R06 R07

	// -----------------------------------------------------------------
	// ribbon change
	// -----------------------------------------------------------------
	assign swap_next = swap_reg ^ ribbon_swap_btn_i;
	wire rib_set = swap_reg && ribbon_reverse_i; // R09
	assign rib_lamp_next = rib_set ||
		(rib_lamp_reg && !ribbon_swap_btn_i); // R10
	assign rib_hold_next = rib_set ||
		(rib_hold_reg && !(ready_btn_i && !rib_lamp_reg)); // R10

	// -----------------------------------------------------------------
	// ready
	// -----------------------------------------------------------------
	assign ready_next = !sense_i.fuse_blown && !timed_fault && // R01
		!overrun_next && !sense_i.paper_low && // R04 R07
		!rib_hold_next && !sense_i.carriage_out &&
		tmr_next == '0; // R20

	// -----------------------------------------------------------------
	// character filter
	// -----------------------------------------------------------------
	wire stop_now = !line_start_i && stop_seen_reg;
	wire prt_ok = printable(char_i.code, charset63_i, stop_now); // R16 R18
	assign stop_seen_next = stop_now || (char_i.valid &&
		!charset63_i && char_i.code == CODE_STOP); // R17

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tmr_reg <= TMR_LOAD;
			run_reg <= '0;
			overrun_reg <= 1'b0;
			low_lamp_reg <= 1'b0;
			swap_reg <= 1'b0;
			rib_lamp_reg <= 1'b0;
			rib_hold_reg <= 1'b0;
			stop_seen_reg <= 1'b0;
		end else begin
			tmr_reg <= tmr_next;
			run_reg <= run_next;
			overrun_reg <= overrun_next;
			low_lamp_reg <= low_lamp_next;
			swap_reg <= swap_next;
			rib_lamp_reg <= rib_lamp_next;
			rib_hold_reg <= rib_hold_next;
			stop_seen_reg <= stop_seen_next;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			actuator_fuse_alarm_o <= 1'b0;
			dc_fault_lamp_o <= 1'b0;
			cabinet_open_lamp_o <= 1'b0;
			thermal_alarm_o <= 1'b0;
			ready_o <= 1'b0;
			printer_summary_alarm_o <= 1'b0;
		end else begin
			actuator_fuse_alarm_o <= sense_i.fuse_blown; // R01
			dc_fault_lamp_o <= sense_i.dc_fault; // R02
			cabinet_open_lamp_o <= cab_open; // R08
			thermal_alarm_o <= sense_i.overtemp; // R11
			ready_o <= ready_next; // R20
			printer_summary_alarm_o <= rib_lamp_next || // R12
				sense_i.dc_fault || overrun_next ||
				sense_i.carriage_out || sense_i.overtemp || cab_open;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			controller_summary_alarm_o <= 1'b0;
			maintenance_misset_lamp_o <= 1'b0;
			key_green_o <= 1'b0;
			key_red_o <= 1'b0;
			ctl_off_req_o <= 1'b0;
			char_o <= '0;
		end else begin
			controller_summary_alarm_o <= |ctl_i; // R13
			maintenance_misset_lamp_o <= |maint_off_normal_i; // R14
			key_green_o <= ctl_power_on_i; // R15
			key_red_o <= !dc_power_on_i; // R15
			ctl_off_req_o <= power_key_btn_i; // R15
			char_o.valid <= char_i.valid && prt_ok; // R16 R17 R18
			char_o.code <= char_i.code;
		end
	end

	// direct register views
	assign paper_feed_overrun_o = overrun_reg;
	assign paper_low_lamp_o = low_lamp_reg;
	assign ribbon_swap_request_o = swap_reg;
	assign ribbon_exhausted_lamp_o = rib_lamp_reg;

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	sequence rib_armed_s;
		swap_reg && ribbon_reverse_i;
	endsequence
	sequence rib_cleared_s;
		rib_lamp_reg && ribbon_swap_btn_i && !ribbon_reverse_i;
	endsequence

	fuse_lamp_a: assert property ( // R01
		sense_i.fuse_blown |=> actuator_fuse_alarm_o && !ready_o)
		else $error("fuse lamp or ready wrong");
	dc_wait_a: assert property ( // R02
		sense_i.dc_fault |=> dc_fault_lamp_o && tmr_reg == TMR_LOAD)
		else $error("dc fault did not reload timer");
	runaway_set_a: assert property ( // R03
		run_hit |=> paper_feed_overrun_o && run_reg == '0)
		else $error("overrun lamp not set");
	runaway_hold_a: assert property ( // R04
		paper_feed_overrun_o && !ready_btn_i |=> paper_feed_overrun_o)
		else $error("overrun lamp cleared on its own");
	manual_feed_a: assert property ( // R05
		!feed_step_i && !feed_stop_i |=> $stable(run_reg))
		else $error("feed count moved without auto feed");
	paper_low_a: assert property ( // R06 R07
		sense_i.paper_low |=> paper_low_lamp_o && !ready_o)
		else $error("paper low lamp wrong");
	low_clear_a: assert property ( // R07
		ready_btn_i && !sense_i.paper_low |=> !paper_low_lamp_o)
		else $error("paper low lamp not cleared");
	cab_lamp_a: assert property ( // R08
		cabinet_open_lamp_o == $past(cab_open))
		else $error("cabinet lamp mismatch");
	ribbon_set_a: assert property ( // R09
		rib_armed_s |=> ribbon_exhausted_lamp_o ##0 !ready_o)
		else $error("ribbon lamp not set");
	ribbon_clr_a: assert property ( // R10
		rib_cleared_s |=> !ribbon_exhausted_lamp_o && !ready_o)
		else $error("ribbon clear wrong");
	thermal_wait_a: assert property ( // R11
		sense_i.overtemp ##1 !timed_fault |=> !ready_o [*8])
		else $error("ready before timing cycle");
	summary_a: assert property ( // R12
		sense_i.dc_fault || sense_i.carriage_out |=> printer_summary_alarm_o)
		else $error("printer summary lamp missing");
	ctl_summary_a: assert property ( // R13
		controller_summary_alarm_o == $past(|ctl_i))
		else $error("controller summary lamp mismatch");
	misset_lamp_a: assert property ( // R14
		maintenance_misset_lamp_o == $past(|maint_off_normal_i))
		else $error("misset lamp mismatch");
	power_key_a: assert property ( // R15
		power_key_btn_i |=> ctl_off_req_o ##1 !$past(power_key_btn_i)
			|| ctl_off_req_o)
		else $error("power key press lost");
	blank_code_a: assert property ( // R16 R18
		char_i.valid && char_i.code == CODE_BLANK |=> !char_o.valid)
		else $error("blank code printed");
	stop_code_a: assert property ( // R17
		char_i.valid && !charset63_i && char_i.code == CODE_STOP
		##1 !line_start_i && !charset63_i [*2] |=> !char_o.valid)
		else $error("character after stop printed");
	ready_timer_a: assert property ( // R19 R20
		ready_o |-> tmr_zero && !paper_feed_overrun_o)
		else $error("ready with timer running");
	manual_only_a: assert property ( // R05
		manual_feed_i && !feed_step_i && !feed_stop_i |=> $stable(run_reg))
		else $error("manual feed moved the feed count");
	dc_lamp_off_a: assert property ( // R02
		!sense_i.dc_fault |=> !dc_fault_lamp_o)
		else $error("dc fault lamp stuck");
	cab_timer_a: assert property ( // R08
		cab_open |=> tmr_reg == TMR_LOAD && !ready_o)
		else $error("interlock did not reload timer");
	defeat_lamp_a: assert property ( // R08
		sense_i.interlock_defeat |=> !cabinet_open_lamp_o)
		else $error("cabinet lamp lit while defeated");
	thermal_lamp_a: assert property ( // R11
		sense_i.overtemp |=> thermal_alarm_o && tmr_reg == TMR_LOAD)
		else $error("thermal lamp or timer wrong");
	ribbon_ignore_a: assert property ( // R09
		!swap_reg && !rib_lamp_reg && ribbon_reverse_i
		|=> !ribbon_exhausted_lamp_o)
		else $error("ribbon lamp set without request");
	ribbon_hold_a: assert property ( // R10
		rib_hold_reg && !ready_btn_i |=> !ready_o)
		else $error("ready without ready press after ribbon");
	summary_heat_a: assert property ( // R12
		sense_i.overtemp || cab_open |=> printer_summary_alarm_o)
		else $error("printer summary lamp missing");
	ready_block_a: assert property ( // R20
		sense_i.fuse_blown || sense_i.carriage_out || sense_i.paper_low
		|=> !ready_o)
		else $error("ready while blocked");
	char_pass_a: assert property ( // R18
		char_i.valid && charset63_i && char_i.code != CODE_BLANK
		|=> char_o.valid && char_o.code == $past(char_i.code))
		else $error("printable character dropped");
	line_restart_a: assert property ( // R17
		line_start_i && char_i.valid && char_i.code != CODE_BLANK &&
		char_i.code != CODE_STOP |=> char_o.valid)
		else $error("new line character suppressed");
	key_lamp_a: assert property ( // R15
		1'b1 |=> key_green_o == $past(ctl_power_on_i) &&
			key_red_o == !$past(dc_power_on_i))
		else $error("power key lamp mismatch");

endmodule

// ===== pfr_panel.sv
// operator pushbuttons and mechanism sensors facing the status block
// assumes the bench drives it between rising edges of mclk_i
module pfr_panel import pfr_pkg::*; (
	input wire logic mclk_i,
	output pfr_sense_t sense_o,
	output pfr_ctl_t ctl_o,
	output logic [5:0] btn_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// -----------------------------------------------------------------
	// buttons: 0 feed, 1 manual, 2 stop, 3 ready, 4 swap, 5 reverse
	// -----------------------------------------------------------------
	initial begin
		sense_o = '0;
		ctl_o = '0;
		btn_o = '0;
	end
	// one-cycle press, then one idle cycle so presses never merge
	task automatic press(input int b);
		btn_o[b] = 1'b1;
		@(negedge mclk_i);
		btn_o[b] = 1'b0;
		@(negedge mclk_i);
	endtask
	task automatic feed(input int b, input int n);
		repeat (n) press(b);
	endtask
	// sensor and controller levels, applied when the caller asks
	task automatic set_sense(input pfr_sense_t s);
		sense_o = s;
	endtask
	task automatic set_ctl(input pfr_ctl_t c);
		ctl_o = c;
	endtask
endmodule

// ===== pfr_status_test.sv
// self-checking bench for the printer fault and ready logic
// assumes pfr_status with a short timing cycle and one step per inch
module pfr_status_test import pfr_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TC = 20;
	logic mclk_i = 1'b0;
	logic rst_n_i;
	pfr_sense_t sense;
	pfr_ctl_t ctl;
	logic [5:0] btn;
	logic [7:0] maint;
	logic ctl_pwr;
	logic dc_pwr;
	logic key;
	logic cs63;
	logic line_st;
	pfr_char_t char_i;
	pfr_char_t char_o;
	logic fuse, dcl, ovr, plow, cab, req, rib, therm, ready_o;
	logic psum, csum, mis, kg, kr, off;
	int n_fail = 0;
	int comparisons = 0;
	always #5 mclk_i = ~mclk_i;
	pfr_panel u_pfr_panel (.mclk_i(mclk_i), .sense_o(sense), .ctl_o(ctl),
		.btn_o(btn));
	pfr_status #(.TIMER_CYCLES(TC), .STEPS_PER_INCH(1)) u_pfr_status (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sense_i(sense),
		.feed_step_i(btn[0]), .manual_feed_i(btn[1]), .feed_stop_i(btn[2]),
		.ready_btn_i(btn[3]), .ribbon_swap_btn_i(btn[4]),
		.ribbon_reverse_i(btn[5]), .ctl_i(ctl), .maint_off_normal_i(maint),
		.ctl_power_on_i(ctl_pwr), .dc_power_on_i(dc_pwr),
		.power_key_btn_i(key), .charset63_i(cs63), .line_start_i(line_st),
		.char_i(char_i), .actuator_fuse_alarm_o(fuse), .dc_fault_lamp_o(dcl),
		.paper_feed_overrun_o(ovr), .paper_low_lamp_o(plow),
		.cabinet_open_lamp_o(cab), .ribbon_swap_request_o(req),
		.ribbon_exhausted_lamp_o(rib), .thermal_alarm_o(therm),
		.ready_o(ready_o), .printer_summary_alarm_o(psum),
		.controller_summary_alarm_o(csum), .maintenance_misset_lamp_o(mis),
		.key_green_o(kg), .key_red_o(kr), .ctl_off_req_o(off),
		.char_o(char_o));
	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	task automatic t_power();
		cyc(TC - 6);
		chk(ready_o, 0);
		cyc(8);
		chk(ready_o, 1);
	endtask
	task automatic t_timed();
		pfr_sense_t s;
		for (int i = 0; i < 3; i++) begin
			s = '0;
			s.dc_fault = (i == 0);
			s.interlock_open = (i == 1);
			s.overtemp = (i == 2);
			u_pfr_panel.set_sense(s);
			cyc(2);
			chk({dcl, cab, therm}, 8'h4 >> i);
			chk({ready_o, psum}, 8'h1);
			s = '0;
			u_pfr_panel.set_sense(s);
			cyc(TC - 5);
			chk(ready_o, 0);
			cyc(8);
			chk(ready_o, 1);
		end
		s = '0;
		s.interlock_open = 1'b1;
		s.interlock_defeat = 1'b1;
		u_pfr_panel.set_sense(s);
		cyc(2);
		chk({cab, ready_o}, 8'h1);
		s = '0;
		u_pfr_panel.set_sense(s);
	endtask
	task automatic t_overrun();
		u_pfr_panel.feed(1, 30);
		chk(ovr, 0);
		u_pfr_panel.feed(0, 21);
		u_pfr_panel.press(2);
		u_pfr_panel.feed(0, 21);
		chk(ovr, 0);
		u_pfr_panel.feed(0, 1);
		chk({ovr, ready_o, psum}, 8'h5);
		cyc(4);
		chk(ovr, 1);
		u_pfr_panel.press(3);
		chk({ovr, ready_o}, 8'h1);
	endtask
	task automatic t_ribbon();
		u_pfr_panel.press(5);
		chk(rib, 0);
		u_pfr_panel.press(4);
		chk(req, 1);
		u_pfr_panel.press(5);
		chk({rib, ready_o, psum}, 8'h5);
		u_pfr_panel.press(4);
		chk({rib, req, ready_o}, 8'h0);
		u_pfr_panel.press(3);
		chk(ready_o, 1);
	endtask
	task automatic t_latch();
		pfr_sense_t s;
		s = '0;
		s.fuse_blown = 1'b1;
		u_pfr_panel.set_sense(s);
		cyc(2);
		chk({fuse, ready_o}, 8'h2);
		s.fuse_blown = 1'b0;
		u_pfr_panel.set_sense(s);
		cyc(2);
		chk({fuse, ready_o}, 8'h1);
		s.paper_low = 1'b1;
		u_pfr_panel.set_sense(s);
		cyc(2);
		chk({plow, ready_o}, 8'h2);
		u_pfr_panel.press(3);
		chk(plow, 1);
		s.paper_low = 1'b0;
		u_pfr_panel.set_sense(s);
		cyc(2);
		chk({plow, ready_o}, 8'h3);
		u_pfr_panel.press(3);
		chk(plow, 0);
		s.carriage_out = 1'b1;
		u_pfr_panel.set_sense(s);
		cyc(2);
		chk({psum, ready_o}, 8'h2);
		s.carriage_out = 1'b0;
		u_pfr_panel.set_sense(s);
	endtask
	task automatic t_ctl();
		for (int i = 0; i < 4; i++) begin
			u_pfr_panel.set_ctl(pfr_ctl_t'(4'h1 << i));
			cyc(2);
			chk(csum, 1);
			u_pfr_panel.set_ctl(pfr_ctl_t'(4'h0));
			cyc(2);
			chk(csum, 0);
		end
		for (int i = 0; i < 8; i++) begin
			maint = 8'h01 << i;
			cyc(2);
			chk(mis, 1);
			maint = '0;
			cyc(2);
			chk(mis, 0);
		end
		chk({kg, kr}, 8'h2);
		ctl_pwr = 1'b0;
		dc_pwr = 1'b0;
		cyc(2);
		chk({kg, kr}, 8'h1);
		key = 1'b1;
		cyc(1);
		key = 1'b0;
		chk(off, 1);
		cyc(1);
		chk(off, 0);
	endtask
	task automatic put(input logic [5:0] c, input logic v);
		char_i = '{valid: 1'b1, code: c};
		cyc(1);
		char_i = '0;
		chk(char_o.valid, v);
		if (v)
			chk(char_o.code, c);
		cyc(1);
	endtask
	task automatic t_char();
		put(6'h05, 0);
		put(6'h01, 1);
		put(6'h3f, 0);
		put(6'h01, 0);
		line_st = 1'b1;
		cyc(1);
		line_st = 1'b0;
		put(6'h01, 1);
		cs63 = 1'b1;
		put(6'h3f, 1);
		put(6'h02, 1);
		put(6'h05, 0);
	endtask
	// -----------------------------------------------------------------
	// main sequence and watchdog
	// -----------------------------------------------------------------
	initial begin
		rst_n_i = 1'b0;
		maint = '0;
		ctl_pwr = 1'b1;
		dc_pwr = 1'b1;
		key = 1'b0;
		cs63 = 1'b0;
		line_st = 1'b0;
		char_i = '0;
		cyc(5);
		rst_n_i = 1'b1;
		t_power();
		t_timed();
		t_overrun();
		t_ribbon();
		t_latch();
		t_ctl();
		t_char();
		give_verdict();
	end
	initial begin
		#20000;
		n_fail++;
		give_verdict();
	end
endmodule
